/* File: src/ebt_ctrl.sv */
// External bus controller with idle, stretch and wait timing per space
//
// Contract
// - Idle/extension register resets to all ones
// - Wait register resets to all ones
// - Post-read idles before access to other space
// - Post-read idles also before same-space write
// - Idle count taken from earlier access space
// - Post-read idle fields in bits 15:8
// - Idle field value equals idle count
// - Same-space idle negates chip select once
// - Write after read uses larger idle count
// - Same-space idle bits 7:4, one cycle
// - Stretch adds one cycle before, one after
// - Stretch enable bits 3:0 per space
// - Write data held through trailing cycle
// - Four-bit wait count per space
// - Zero waits ignores external wait input
// - Plain access takes two bus states
// - External wait sampled one cycle early
// - Stretch cycles assert only chip select
// - Existing idles reduce inserted idle count
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module ebt_ctrl
   import ebt_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic hw_standby_in,
   input wire logic [EBT_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic acc_req_in,
   input wire logic [1:0] acc_space_in,
   input wire logic acc_write_in,
   input wire logic [1:0] acc_byte_en_in,
   input wire logic [15:0] acc_wdata_in,
   output logic acc_ack_out,
   output logic acc_rvalid_out,
   output logic [15:0] acc_rdata_out,
   output logic [3:0] space_select_n_out,
   output logic read_strobe_n_out,
   output logic upper_write_strobe_n_out,
   output logic lower_write_strobe_n_out,
   output logic [15:0] ext_data_out,
   output logic ext_data_oe_out,
   input wire logic [15:0] ext_data_in,
   input wire logic ext_wait_n_in
);
   ////////////////////////////////////////////////////////////////////
   // Field extraction
   function automatic logic [1:0] iw_of(input logic [15:0] r,
                                        input logic [1:0] sp);
      iw_of = r[EBT_IW_LSB + EBT_IW_W * sp +: EBT_IW_W];
   endfunction : iw_of

   function automatic logic [3:0] wc_of(input logic [15:0] r,
                                        input logic [1:0] sp);
      wc_of = r[EBT_WC_W * sp +: EBT_WC_W];
   endfunction : wc_of

   ////////////////////////////////////////////////////////////////////
   // Register file on Avalon-MM
   logic [15:0] idle_ext_r;
   logic [15:0] wait_ctl_r;
   logic wreq_r;
   logic [31:0] rdata_r;
   wire bus_req = avs_read_in | avs_write_in;
   wire hit_idle = avs_address_in == EBT_OFS_IDLE_EXT;
   wire hit_wait = avs_address_in == EBT_OFS_WAIT;
   wire wr_take = avs_write_in & ~wreq_r;
   wire [15:0] rd_mux = hit_idle ? idle_ext_r :
                        hit_wait ? wait_ctl_r : 16'h0000;
   wire [15:0] be_mask = {{8{avs_byteenable_in[1]}},
                          {8{avs_byteenable_in[0]}}};
   wire [15:0] idle_ext_nxt = (idle_ext_r & ~be_mask) |
                              (avs_writedata_in[15:0] & be_mask);
   wire [15:0] wait_ctl_nxt = (wait_ctl_r & ~be_mask) |
                              (avs_writedata_in[15:0] & be_mask);

   // One wait cycle, then the answer in the cycle waitrequest is low
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wreq_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wreq_r <= ~(bus_req & wreq_r);
         if (avs_read_in & wreq_r)
            rdata_r <= {16'h0000, rd_mux};
      end
   end

   // Only power-on reset and hardware standby reinitialise
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         idle_ext_r <= EBT_IDLE_EXT_RST;
         wait_ctl_r <= EBT_WAIT_RST;
      end else if (hw_standby_in) begin
         idle_ext_r <= EBT_IDLE_EXT_RST;
         wait_ctl_r <= EBT_WAIT_RST;
      end else begin
         if (wr_take & hit_idle)
            idle_ext_r <= idle_ext_nxt;
         if (wr_take & hit_wait)
            wait_ctl_r <= wait_ctl_nxt;
      end
   end

   assign avs_waitrequest_out = wreq_r;
   assign avs_readdata_out = rdata_r;

   ////////////////////////////////////////////////////////////////////
   // Access sequencer state
   ebt_state_t state_r, state_nxt, start_st;
   logic [1:0] sp_r, last_sp_r, be_r, gap_r, idle_cnt_r;
   logic wr_r, last_rd_r, hist_r, stretch_r, ack_r, wait_smp_r;
   logic [15:0] wd_r;
   logic [3:0] wc_r, wcnt_r;

   wire in_idle = state_r == EBT_IDLE;
   wire last_st = (state_r == EBT_T2 & ~stretch_r) |
                  state_r == EBT_TRAIL;
   wire accept = acc_req_in & ~ack_r & (in_idle | last_st);
   // While the final state runs, the previous access is the current one
   wire [1:0] prev_sp = in_idle ? last_sp_r : sp_r;
   wire prev_rd = in_idle ? last_rd_r : ~wr_r;
   wire prev_ok = in_idle ? hist_r : 1'b1;
   wire same_sp = prev_ok & (acc_space_in == prev_sp);
   wire rd_hazard = prev_ok & prev_rd & (~same_sp | acc_write_in);
   wire [1:0] pr_need = rd_hazard ? iw_of(idle_ext_r, prev_sp)
                                  : 2'b00;
   wire [1:0] cw_need = same_sp ?
        {1'b0, idle_ext_r[EBT_CW_LSB + prev_sp]} : 2'b00;
   wire [1:0] need = (pr_need > cw_need) ? pr_need : cw_need;
   wire [2:0] have = in_idle ? {1'b0, idle_cnt_r} + 3'd1 : 3'd0;
   wire [2:0] short3 = ({1'b0, need} > have) ?
        {1'b0, need} - have : 3'd0;
   wire [1:0] short = short3[1:0];
   wire new_stretch = idle_ext_r[EBT_SW_LSB + acc_space_in];
   wire [3:0] new_wc = wc_of(wait_ctl_r, acc_space_in);
   wire wait_end = (wcnt_r == 4'h1) & ~wait_smp_r;

   assign start_st = (short != 2'b00) ? EBT_GAP :
                     new_stretch ? EBT_LEAD : EBT_T1;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         EBT_IDLE: begin
            if (accept)
               state_nxt = start_st;
         end
         EBT_GAP: begin
            if (gap_r == 2'h1)
               state_nxt = stretch_r ? EBT_LEAD : EBT_T1;
         end
         EBT_LEAD: state_nxt = EBT_T1;
         EBT_T1: state_nxt = (wc_r != 4'h0) ? EBT_TW : EBT_T2;
         EBT_TW: begin
            if (wait_end)
               state_nxt = EBT_T2;
         end
         EBT_T2: begin
            if (stretch_r)
               state_nxt = EBT_TRAIL;
            else
               state_nxt = accept ? start_st : EBT_IDLE;
         end
         EBT_TRAIL: state_nxt = accept ? start_st : EBT_IDLE;
         default: state_nxt = EBT_IDLE;
      endcase
   end

   // Per-access settings are frozen when the access is taken
   wire [1:0] sp_nxt = accept ? acc_space_in : sp_r;
   wire wr_nxt = accept ? acc_write_in : wr_r;
   wire [1:0] be_nxt = accept ? acc_byte_en_in : be_r;
   wire [15:0] wd_nxt = accept ? acc_wdata_in : wd_r;
   wire cs_on = state_nxt inside {EBT_LEAD, EBT_T1, EBT_TW, EBT_T2,
                                  EBT_TRAIL};
   wire strobe_ph = state_nxt inside {EBT_T1, EBT_TW, EBT_T2};
   wire wstrobe_ph = state_nxt inside {EBT_T1, EBT_TW};
   wire oe_nxt = wr_nxt & (strobe_ph | state_nxt == EBT_TRAIL);
   wire [3:0] cs_n_nxt = cs_on ? ~(4'h1 << sp_nxt) : 4'hF;

   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r <= EBT_IDLE;
         sp_r <= 2'h0;
         wr_r <= 1'b0;
         be_r <= 2'h0;
         wd_r <= 16'h0000;
         wc_r <= 4'h0;
         stretch_r <= 1'b0;
         ack_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sp_r <= sp_nxt;
         wr_r <= wr_nxt;
         be_r <= be_nxt;
         wd_r <= wd_nxt;
         ack_r <= accept;
         if (accept) begin
            wc_r <= new_wc;
            stretch_r <= new_stretch;
         end
      end
   end

   // Gap, wait and history counters
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gap_r <= 2'h0;
         wcnt_r <= 4'h0;
         wait_smp_r <= 1'b0;
         last_sp_r <= 2'h0;
         last_rd_r <= 1'b0;
         hist_r <= 1'b0;
         idle_cnt_r <= 2'h0;
      end else begin
         wait_smp_r <= ~ext_wait_n_in;
         if (accept)
            gap_r <= short;
         else if (state_r == EBT_GAP)
            gap_r <= gap_r - 2'h1;
         if (state_r == EBT_T1)
            wcnt_r <= wc_r;
         else if (state_r == EBT_TW && wcnt_r > 4'h1)
            wcnt_r <= wcnt_r - 4'h1;
         if (last_st) begin
            last_sp_r <= sp_r;
            last_rd_r <= ~wr_r;
            hist_r <= 1'b1;
         end
         if (!in_idle)
            idle_cnt_r <= 2'h0;
         else if (idle_cnt_r != EBT_IW_MAX)
            idle_cnt_r <= idle_cnt_r + 2'h1;
      end
   end

   // Pins and answers, each from a flip-flop
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         space_select_n_out <= 4'hF;
         read_strobe_n_out <= 1'b1;
         upper_write_strobe_n_out <= 1'b1;
         lower_write_strobe_n_out <= 1'b1;
         ext_data_out <= 16'h0000;
         ext_data_oe_out <= 1'b0;
         acc_rvalid_out <= 1'b0;
         acc_rdata_out <= 16'h0000;
      end else begin
         space_select_n_out <= cs_n_nxt;
         read_strobe_n_out <= ~(strobe_ph & ~wr_nxt);
         upper_write_strobe_n_out <= ~(wstrobe_ph & wr_nxt & be_nxt[1]);
         lower_write_strobe_n_out <= ~(wstrobe_ph & wr_nxt & be_nxt[0]);
         ext_data_out <= wd_nxt;
         ext_data_oe_out <= oe_nxt;
         acc_rvalid_out <= (state_r == EBT_T2) & ~wr_r;
         if (state_r == EBT_T2 && !wr_r)
            acc_rdata_out <= ext_data_in;
      end
   end

   assign acc_ack_out = ack_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking ck @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   chk_idle_reg_standby: assert property (
      hw_standby_in |=> idle_ext_r == 16'hFFFF)
      else $error("idle register not reinitialised");
   chk_wait_reg_standby: assert property (
      hw_standby_in |=> wait_ctl_r == 16'hFFFF)
      else $error("wait register not reinitialised");
   chk_other_space_gap: assert property (
      (state_r == EBT_T2 && !wr_r && !stretch_r && accept &&
       acc_space_in != sp_r && iw_of(idle_ext_r, sp_r) == 2'h3)
      |=> (space_select_n_out == 4'hF)[*3])
      else $error("three idles missing after read");
   chk_read_write_gap: assert property (
      (state_r == EBT_T2 && !wr_r && !stretch_r && accept &&
       acc_write_in && iw_of(idle_ext_r, sp_r) == 2'h2)
      |=> (state_r == EBT_GAP)[*2] ##1 state_r != EBT_GAP)
      else $error("two idles wrong before write");
   chk_earlier_setting: assert property (
      (state_r == EBT_T2 && !wr_r && !stretch_r && accept &&
       acc_space_in != sp_r && iw_of(idle_ext_r, sp_r) == 2'h0)
      |=> state_r inside {EBT_LEAD, EBT_T1})
      else $error("idle taken from later space");
   chk_same_space_idle: assert property (
      (state_r == EBT_T2 && wr_r && !stretch_r && accept &&
       acc_space_in == sp_r && idle_ext_r[EBT_CW_LSB + sp_r])
      |=> state_r == EBT_GAP ##1 state_r != EBT_GAP)
      else $error("same space idle wrong");
   chk_gap_select_off: assert property (
      state_r inside {EBT_IDLE, EBT_GAP} |-> space_select_n_out == 4'hF)
      else $error("select active in idle");
   chk_stretch_strobes: assert property (
      state_r inside {EBT_LEAD, EBT_TRAIL} |-> read_strobe_n_out &&
      upper_write_strobe_n_out && lower_write_strobe_n_out &&
      space_select_n_out != 4'hF)
      else $error("strobe active in stretch cycle");
   chk_trail_data_hold: assert property (
      state_r == EBT_TRAIL && wr_r |-> ext_data_oe_out)
      else $error("write data dropped in trailing cycle");
   chk_no_wait_two: assert property (
      state_r == EBT_T1 && wc_r == 4'h0 |=> state_r == EBT_T2)
      else $error("zero wait access not two states");
   chk_wait_min_count: assert property (
      state_r == EBT_T1 && wc_r == 4'h3 |=>
      (state_r == EBT_TW)[*3])
      else $error("fewer waits than programmed");
   chk_timing_frozen: assert property (
      state_r inside {EBT_T1, EBT_TW} |=> $stable(wc_r) && $stable(stretch_r))
      else $error("timing changed inside access");

   cov_read_waits: cover property (state_r == EBT_TW && wr_r == 1'b0
      ##1 state_r == EBT_T2);
   cov_stretch_write: cover property (state_r == EBT_TRAIL && wr_r);
   cov_gap_then_access: cover property (state_r == EBT_GAP
      ##1 state_r inside {EBT_LEAD, EBT_T1});
   cov_ext_wait: cover property (state_r == EBT_TW && wcnt_r == 4'h1
      && wait_smp_r);
endmodule : ebt_ctrl
`default_nettype wire

/* File: common/ebt_pkg.sv */
// Constants and types for the external bus idle and wait timing block
package ebt_pkg;
   ////////////////////////////////////////////////////////////////////
   // Register map, Avalon byte addresses
   localparam int EBT_ADDR_W = 4;
   localparam logic [3:0] EBT_OFS_IDLE_EXT = 4'h0;
   localparam logic [3:0] EBT_OFS_WAIT = 4'h4;
   localparam logic [15:0] EBT_IDLE_EXT_RST = 16'hFFFF;
   localparam logic [15:0] EBT_WAIT_RST = 16'hFFFF;
   ////////////////////////////////////////////////////////////////////
   // Field layout
   localparam int EBT_NSP = 4;
   localparam int EBT_IW_LSB = 8;
   localparam int EBT_IW_W = 2;
   localparam int EBT_CW_LSB = 4;
   localparam int EBT_SW_LSB = 0;
   localparam int EBT_WC_W = 4;
   localparam logic [1:0] EBT_IW_MAX = 2'h3;
   ////////////////////////////////////////////////////////////////////
   // Bus states: idle, gap, leading stretch, T1, wait, T2, trailing
   typedef enum logic [2:0] {
      EBT_IDLE, EBT_GAP, EBT_LEAD, EBT_T1, EBT_TW, EBT_T2, EBT_TRAIL
   } ebt_state_t;
endpackage : ebt_pkg

/* File: dv/ebt_ext_mem.sv */
// External memory model: one word per space, wait pin, released-bus pattern
`timescale 1ns/10ps
`default_nettype none
module ebt_ext_mem (
   input wire logic clk_in,
   input wire logic [3:0] sel_n_in,
   input wire logic rd_n_in,
   input wire logic [1:0] wr_n_in,
   input wire logic [15:0] data_in,
   input wire logic [3:0] stall_in,
   output logic [15:0] data_out,
   output logic wait_n_out
);
   logic [15:0] mem [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] last = 16'h0000;
   logic [3:0] cnt = 4'h0;
   logic act;
   int sp;
   always_comb begin
      sp = 0;
      for (int i = 0; i < 4; i++) if (!sel_n_in[i]) sp = i;
   end
   assign act = sel_n_in != 4'hF;
   // Wait held low for the first stall_in selected cycles
   assign wait_n_out = !(act && cnt < stall_in);
   // Undriven bus shows a pattern that changes every cycle
   assign data_out = (act && !rd_n_in) ? mem[sp] : ~last;
   always @(posedge clk_in) begin
      cnt <= act ? cnt + 4'h1 : 4'h0;
      last <= data_out;
      if (!wr_n_in[1]) mem[sp][15:8] <= data_in[15:8];
      if (!wr_n_in[0]) mem[sp][7:0] <= data_in[7:0];
   end
endmodule : ebt_ext_mem
`default_nettype wire

/* File: dv/ebt_ctrl_tb.sv */
// Self-checking bench for the external bus timing controller
`timescale 1ns/10ps
`default_nettype none
module ebt_ctrl_tb;
   import ebt_pkg::*;
   typedef struct {int cs; int st; int gap; logic wr;
                   logic [15:0] d;} ebt_exp_t;
   localparam int S2[11] = '{0, 1, 0, 0, 0, 2, 2, 3, 2, 1, 1};
   localparam int W2[11] = '{0, 0, 0, 0, 1, 1, 1, 0, 0, 0, 1};
   logic clk = 1'b0, rst = 1'b1, stby = 1'b0, avr = 1'b0, avw = 1'b0;
   logic [EBT_ADDR_W-1:0] ava = '0;
   logic [31:0] avd = '0, avq;
   logic [3:0] avb = '0, sel_n, stall = 4'h0;
   logic avwt, req = 1'b0, wr = 1'b0, ack, rv, rd_n, wrh_n, wrl_n, xoe, xwn;
   logic [1:0] sp = '0, be = '0;
   logic [15:0] wd = '0, rdata, xdo, xdi;
   int iw[4], cw[4], sw[4], wt[4];
   logic [15:0] mm[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
   ebt_exp_t qx[$];
   logic [15:0] qr[$];
   int psp = 0, prd = 0, err_total = 0, check_count = 0, cyc = 0;
   int n_cs = 0, n_st = 0, n_gap = 0;
   logic [3:0] psel = 4'hF;
   logic poe = 1'b0;
   logic [15:0] pd = '0;
   ebt_exp_t ex;
   logic [31:0] q;

   ebt_ctrl i_ebt_ctrl (.core_clk_in(clk), .sys_rst_in(rst),
      .hw_standby_in(stby), .avs_address_in(ava), .avs_read_in(avr),
      .avs_write_in(avw), .avs_writedata_in(avd), .avs_byteenable_in(avb),
      .avs_readdata_out(avq), .avs_waitrequest_out(avwt), .acc_req_in(req),
      .acc_space_in(sp), .acc_write_in(wr), .acc_byte_en_in(be),
      .acc_wdata_in(wd), .acc_ack_out(ack), .acc_rvalid_out(rv),
      .acc_rdata_out(rdata), .space_select_n_out(sel_n),
      .read_strobe_n_out(rd_n), .upper_write_strobe_n_out(wrh_n),
      .lower_write_strobe_n_out(wrl_n), .ext_data_out(xdo),
      .ext_data_oe_out(xoe), .ext_data_in(xdi), .ext_wait_n_in(xwn));
   ebt_ext_mem i_ebt_ext_mem (.clk_in(clk), .sel_n_in(sel_n), .rd_n_in(rd_n),
      .wr_n_in({wrh_n, wrl_n}), .data_in(xdo), .stall_in(stall),
      .data_out(xdi), .wait_n_out(xwn));

   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (e !== g) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   // One Avalon transfer, held until waitrequest is seen low
   task automatic av(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      ava <= a;
      avd <= d;
      avb <= b;
      avw <= w;
      avr <= !w;
      do @(posedge clk); while (avwt !== 1'b0);
      q = avq;
      avw <= 1'b0;
      avr <= 1'b0;
   endtask : av
   task automatic set_cfg(input logic [15:0] ie, input logic [15:0] wc);
      av(1'b1, EBT_OFS_IDLE_EXT, {16'hA5A5, ie}, 4'hF);
      av(1'b1, EBT_OFS_WAIT, {16'h5A5A, wc}, 4'hF);
      av(1'b0, EBT_OFS_IDLE_EXT, 32'h0, 4'hF);
      chk("idle_ext_reg", {16'h0, ie}, q);
      av(1'b0, EBT_OFS_WAIT, 32'h0, 4'hF);
      chk("wait_reg", {16'h0, wc}, q);
      for (int i = 0; i < 4; i++) begin
         iw[i] = ie[8 + 2 * i +: 2];
         cw[i] = ie[4 + i];
         sw[i] = ie[i];
         wt[i] = wc[4 * i +: 4];
      end
   endtask : set_cfg
   // Presents one access and predicts its timing from the settings
   task automatic acc(input int s, input int w, input int g, input int xe);
      ebt_exp_t e;
      logic [1:0] b;
      b = 2'($urandom_range(3, 1));
      e.d = 16'($urandom);
      e.wr = w[0];
      e.cs = 2 + wt[s] + xe + 2 * sw[s];
      e.st = (w ? 1 : 2) + wt[s] + xe;
      e.gap = -1;
      if (g != 0) begin
         e.gap = (prd != 0 && (s != psp || w != 0)) ? iw[psp] : 0;
         if (s == psp && cw[s] > e.gap) e.gap = cw[s];
      end
      if (w != 0 && b[1]) mm[s][15:8] = e.d[15:8];
      if (w != 0 && b[0]) mm[s][7:0] = e.d[7:0];
      if (w == 0) qr.push_back(mm[s]);
      qx.push_back(e);
      psp = s;
      prd = (w == 0);
      req <= 1'b1;
      sp <= 2'(s);
      wr <= w[0];
      be <= b;
      wd <= e.d;
      do @(posedge clk); while (ack !== 1'b1);
   endtask : acc
   task automatic stop();
      req <= 1'b0;
      repeat (40) @(posedge clk);
   endtask : stop
   ////////////////////////////////////////////////////////////////////
   // Measures each bus cycle at the pins and compares with the model
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         wrap_up();
      end else if (!rst) begin
         if (psel != 4'hF && sel_n != psel) begin
            ex = qx.pop_front();
            chk("select_len", ex.cs, n_cs);
            chk("strobe_len", ex.st, n_st);
            if (ex.gap >= 0) chk("idle_gap", ex.gap, n_gap);
            if (ex.wr) chk("wr_hold", {1'b1, ex.d}, {poe, pd});
            n_cs = 0;
            n_st = 0;
            n_gap = 0;
         end
         if (sel_n != 4'hF) begin
            n_cs++;
            if (!(rd_n && wrh_n && wrl_n)) n_st++;
            poe = xoe;
            pd = xdo;
         end else n_gap++;
         if (rv) chk("read_data", qr.pop_front(), rdata);
         psel = sel_n;
      end
   end
   initial begin
      void'($urandom(32'h7765));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      av(1'b0, EBT_OFS_IDLE_EXT, 32'h0, 4'hF);
      chk("idle_ext_rst", {16'h0, EBT_IDLE_EXT_RST}, q);
      av(1'b1, EBT_OFS_WAIT, 32'hFFFF1234, 4'h1);
      av(1'b1, 4'h8, 32'h0, 4'hF);
      av(1'b0, 4'h8, 32'h0, 4'hF);
      chk("unmapped", 32'h0, q);
      av(1'b0, EBT_OFS_WAIT, 32'h0, 4'hF);
      chk("wait_lane", 32'h0000FF34, q);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      av(1'b0, EBT_OFS_WAIT, 32'h0, 4'hF);
      chk("wait_standby", {16'h0, EBT_WAIT_RST}, q);
      // Reset settings: three idles, stretch and fifteen waits
      set_cfg(16'hFFFF, 16'hFFFF);
      acc(0, 0, 0, 0);
      acc(1, 0, 1, 0);
      acc(1, 1, 1, 0);
      stop();
      // Every idle code, mixed same-space idle, wait pin ignored
      stall <= 4'h2;
      set_cfg(16'h1B50, 16'h0000);
      for (int i = 0; i < 11; i++) begin
         if (i == 2) begin
            // Let the read finish so idles have already elapsed
            req <= 1'b0;
            do @(posedge clk); while (rv !== 1'b1);
         end
         acc(S2[i], W2[i], i, 0);
      end
      stop();
      set_cfg(16'h0000, 16'h0002);
      acc(0, 0, 0, 1);
      stop();
      stall <= 4'h0;
      for (int r = 0; r < 8; r++) begin
         set_cfg({8'($urandom), 4'hF, 4'($urandom)}, 16'($urandom) & 16'h3333);
         for (int i = 0; i < 8; i++)
            acc($urandom_range(3, 0), $urandom_range(1, 0), i, 0);
         stop();
      end
      chk("pending", 0, qx.size() + qr.size());
      wrap_up();
   end
endmodule : ebt_ctrl_tb
`default_nettype wire
